// File: tap_sync.sv
/*
 * Shared constants of the test access port and a two-flop synchroniser.
 * Assumes the synchroniser input is quasi-static or toggle coded when
 * wider than one bit.
 */
package tap_pkg;
    // instruction codes
    localparam logic [3:0] INS_BYPASS   = 4'h0;
    localparam logic [3:0] INS_SAMPLE   = 4'h1;
    localparam logic [3:0] INS_IDCODE   = 4'h2;
    localparam logic [3:0] INS_USERCODE = 4'h3;
    localparam logic [3:0] INS_CLAMP    = 4'h4;
    localparam logic [3:0] INS_HIGHZ    = 4'h5;
    localparam logic [3:0] INS_EXTEST   = 4'h7;
    localparam logic [3:0] INS_IFACE    = 4'h8;
    localparam logic [3:0] INS_REG_RD   = 4'h9;
    localparam logic [3:0] INS_REG_WR   = 4'ha;
    localparam logic [3:0] IR_CAPTURE   = 4'h1;
    localparam int         IR_W         = 4;
    // data register geometry
    localparam int         DR_W         = 32;
    localparam int         BSR_CELLS    = 24;
    localparam int         PIN_N        = 12;
    localparam int         BC4_PIN      = 3;
    localparam int         ADDR_W       = 7;
    localparam int         DATA_W       = 8;
    localparam int         WR_ADDR_LSB  = 8;
    localparam logic [5:0] LEN_ONE      = 6'h01;
    localparam logic [5:0] LEN_BSR      = 6'h18;
    localparam logic [5:0] LEN_ID       = 6'h20;
    localparam logic [5:0] LEN_RD       = 6'h08;
    localparam logic [5:0] LEN_WR       = 6'h0f;
    // identification field positions
    localparam int         ID_MFR_LSB   = 1;
    localparam int         ID_PART_LSB  = 12;
    localparam int         ID_VER_LSB   = 28;

    typedef enum logic [3:0] {
        TAP_TLR    = 4'h0,
        TAP_RTI    = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR  = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PA_DR  = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UP_DR  = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SH_IR  = 4'hb,
        TAP_EX1_IR = 4'hc,
        TAP_PA_IR  = 4'hd,
        TAP_EX2_IR = 4'he,
        TAP_UP_IR  = 4'hf
    } tap_state_t;
endpackage

`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_en,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_q  <= '0;
        end else if (i_en) begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

// File: boundary_scan_tap.sv
/*
 * Boundary scan test access port: tap controller, instruction register,
 * bypass, identification, user code, 24-cell boundary register and the
 * scan register access instructions.
 * Assumes the pads apply pull-ups on the test inputs when asked, and the
 * internal register file answers reads combinationally from o_reg_addr.
 */
// Contract
// - ir codes: 0 bypass,1 sample/preload,2 idcode,3 usercode,4 clamp,5 highz,7 extest
// - dr length 24 for sample/preload/extest, 32 for idcode/usercode
// - tms sampled each rising tck edge picks next tap state
// - tdi sampled rising edge into ir or selected dr chain
// - tdo updates on the falling tck edge
// - tdo driven only while shifting, released otherwise
// - five tms-high cycles reach test-logic-reset from any state
// - entering test-logic-reset loads idcode into the instruction register
// - static tck keeps tap state and register contents
// - undriven tck, tms and tdi read as logic one
// - bypass passes tdi to tdo through one bit, device unaffected
// - 24 cells: odd control cells, even pin cells, cell 6 observe-only
// - pin cells map to the listed pins, each governed by cell above
// - idcode: bit0 one, 11-bit maker, 16-bit part, 4-bit version
// - user code returns three product bytes then a version byte
// - instruction 8 one bit; update of 1 disables host interfaces
// - instruction 9 reads byte at current address, update sets new address
// - instruction 10 carries address and data, writes the internal register
`timescale 1ns/1ps
module boundary_scan_tap #(
    parameter logic [3:0]  ID_VERSION = 4'h5,     // arbitrary value
    parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h155   // arbitrary value
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_tck,
    input  wire logic        i_tms,
    input  wire logic        i_tdi,
    output logic             o_tdo,
    output logic             o_tdo_oe,
    output logic [2:0]       o_test_pullup_en,
    input  wire logic [31:0] i_user_code,
    output logic             o_host_if_off,
    output logic [6:0]       o_reg_addr,
    output logic [7:0]       o_reg_wdata,
    output logic             o_reg_wr,
    input  wire logic [7:0]  i_reg_rdata,
    input  wire logic [11:0] i_core_out,
    input  wire logic [11:0] i_core_oe,
    input  wire logic [11:0] i_pad_in,
    output logic [11:0]      o_pad_out,
    output logic [11:0]      o_pad_oe
);
    tap_pkg::tap_state_t state;
    tap_pkg::tap_state_t next_state;
    logic                tck_rst_n;
    logic [3:0]          ir_sh;
    logic [3:0]          ir;
    logic [31:0]         dr;
    logic                bypass;
    logic [23:0]         bsr_upd;
    logic                if_off;
    logic [6:0]          cur_addr;
    logic [6:0]          wr_addr;
    logic [7:0]          wr_data;
    logic [7:0]          rd_tck;
    logic                addr_tgl;
    logic                wr_tgl;
    logic [31:0]         user_s;
    logic [23:0]         cap_s;
    logic                ack_s;
    logic                ack_seen;
    logic                addr_s;
    logic                addr_seen;
    logic                wr_s;
    logic                wr_seen;
    logic                if_off_s;
    logic                rd_pend;
    logic                ack_tgl;
    logic [7:0]          rd_sys;
    logic [23:0]         cap_vec;
    logic [31:0]         id_word;
    logic                drive_test;

    // decode of the active instruction to its chain length
    function automatic logic [5:0] dr_len(input logic [3:0] ins);
        unique case (ins)
            tap_pkg::INS_SAMPLE, tap_pkg::INS_EXTEST:   dr_len = tap_pkg::LEN_BSR;
            tap_pkg::INS_IDCODE, tap_pkg::INS_USERCODE: dr_len = tap_pkg::LEN_ID;
            tap_pkg::INS_REG_RD:                        dr_len = tap_pkg::LEN_RD;
            tap_pkg::INS_REG_WR:                        dr_len = tap_pkg::LEN_WR;
            default:                                    dr_len = tap_pkg::LEN_ONE;
        endcase
    endfunction

    // instructions whose scan path is the single bypass bit
    function automatic logic uses_bypass(input logic [3:0] ins);
        uses_bypass = (ins == tap_pkg::INS_BYPASS) || (ins == tap_pkg::INS_CLAMP) ||
                      (ins == tap_pkg::INS_HIGHZ) || (dr_len(ins) == tap_pkg::LEN_ONE &&
                      ins != tap_pkg::INS_IFACE);
    endfunction

    // pads hold the test inputs high when nobody drives them
    assign o_test_pullup_en = 3'h7;

    // reset brought into the test clock domain
    sync_2ff #(.WIDTH(1)) u_rst_sync (
        .i_clk   (i_tck),
        .i_rst_n (1'b1),
        .i_en    (1'b1),
        .i_d     (i_rst_n),
        .o_q     (tck_rst_n)
    );

    // pad levels and core enables seen by the capture stage
    sync_2ff #(.WIDTH(24)) u_cap_sync (
        .i_clk   (i_tck),
        .i_rst_n (tck_rst_n),
        .i_en    (1'b1),
        .i_d     (cap_vec),
        .o_q     (cap_s)
    );

    // user code bytes are static after the memory load
    sync_2ff #(.WIDTH(32)) u_user_sync (
        .i_clk   (i_tck),
        .i_rst_n (tck_rst_n),
        .i_en    (1'b1),
        .i_d     (i_user_code),
        .o_q     (user_s)
    );

    // read acknowledge back into the test clock domain
    sync_2ff #(.WIDTH(1)) u_ack_sync (
        .i_clk   (i_tck),
        .i_rst_n (tck_rst_n),
        .i_en    (1'b1),
        .i_d     (ack_tgl),
        .o_q     (ack_s)
    );

    // even cells see the pad, odd cells the core enable
    genvar k;
    generate
        for (k = 0; k < tap_pkg::PIN_N; k++) begin : g_cell
            assign cap_vec[2*k]   = i_pad_in[k];
            assign cap_vec[2*k+1] = i_core_oe[k];
        end
    endgenerate

    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // tap next state from state and sampled tms
    always_comb begin
        unique case (state)
            tap_pkg::TAP_TLR:    next_state = i_tms ? tap_pkg::TAP_TLR    : tap_pkg::TAP_RTI;
            tap_pkg::TAP_RTI:    next_state = i_tms ? tap_pkg::TAP_SEL_DR : tap_pkg::TAP_RTI;
            tap_pkg::TAP_SEL_DR: next_state = i_tms ? tap_pkg::TAP_SEL_IR : tap_pkg::TAP_CAP_DR;
            tap_pkg::TAP_CAP_DR: next_state = i_tms ? tap_pkg::TAP_EX1_DR : tap_pkg::TAP_SH_DR;
            tap_pkg::TAP_SH_DR:  next_state = i_tms ? tap_pkg::TAP_EX1_DR : tap_pkg::TAP_SH_DR;
            tap_pkg::TAP_EX1_DR: next_state = i_tms ? tap_pkg::TAP_UP_DR  : tap_pkg::TAP_PA_DR;
            tap_pkg::TAP_PA_DR:  next_state = i_tms ? tap_pkg::TAP_EX2_DR : tap_pkg::TAP_PA_DR;
            tap_pkg::TAP_EX2_DR: next_state = i_tms ? tap_pkg::TAP_UP_DR  : tap_pkg::TAP_SH_DR;
            tap_pkg::TAP_UP_DR:  next_state = i_tms ? tap_pkg::TAP_SEL_DR : tap_pkg::TAP_RTI;
            tap_pkg::TAP_SEL_IR: next_state = i_tms ? tap_pkg::TAP_TLR    : tap_pkg::TAP_CAP_IR;
            tap_pkg::TAP_CAP_IR: next_state = i_tms ? tap_pkg::TAP_EX1_IR : tap_pkg::TAP_SH_IR;
            tap_pkg::TAP_SH_IR:  next_state = i_tms ? tap_pkg::TAP_EX1_IR : tap_pkg::TAP_SH_IR;
            tap_pkg::TAP_EX1_IR: next_state = i_tms ? tap_pkg::TAP_UP_IR  : tap_pkg::TAP_PA_IR;
            tap_pkg::TAP_PA_IR:  next_state = i_tms ? tap_pkg::TAP_EX2_IR : tap_pkg::TAP_PA_IR;
            tap_pkg::TAP_EX2_IR: next_state = i_tms ? tap_pkg::TAP_UP_IR  : tap_pkg::TAP_SH_IR;
            tap_pkg::TAP_UP_IR:  next_state = i_tms ? tap_pkg::TAP_SEL_DR : tap_pkg::TAP_RTI;
        endcase
    end

    // state only moves on a tck edge, so a stopped clock holds it
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n)
            state <= tap_pkg::TAP_TLR;
        else
            state <= next_state;
    end

    // instruction shift and update; reset state forces the default
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n || next_state == tap_pkg::TAP_TLR) begin
            ir_sh <= tap_pkg::IR_CAPTURE;
            ir    <= tap_pkg::INS_IDCODE;
        end else if (state == tap_pkg::TAP_CAP_IR) begin
            ir_sh <= tap_pkg::IR_CAPTURE;
        end else if (state == tap_pkg::TAP_SH_IR) begin
            ir_sh <= {i_tdi, ir_sh[3:1]};
        end else if (state == tap_pkg::TAP_UP_IR) begin
            ir    <= ir_sh;
        end
    end

    // data chain: capture by instruction, shift into the top of its length
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            dr     <= '0;
            bypass <= 1'b0;
        end else if (state == tap_pkg::TAP_CAP_DR) begin
            bypass <= 1'b0;
            unique case (ir)
                tap_pkg::INS_SAMPLE, tap_pkg::INS_EXTEST: dr <= {8'h00, cap_s};
                tap_pkg::INS_IDCODE:   dr <= id_word;
                tap_pkg::INS_USERCODE: dr <= user_s;
                tap_pkg::INS_REG_RD:   dr <= {24'h000000, rd_tck};
                tap_pkg::INS_REG_WR:   dr <= {17'h00000, wr_addr, wr_data};
                default:               dr <= '0;
            endcase
        end else if (state == tap_pkg::TAP_SH_DR) begin
            bypass <= i_tdi;
            dr     <= dr >> 1;
            dr[5'(dr_len(ir) - 6'h01)] <= i_tdi;
        end
    end

    // update stage of the boundary and vendor registers
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            bsr_upd  <= '0;
            if_off   <= 1'b0;
            cur_addr <= '0;
            wr_addr  <= '0;
            wr_data  <= '0;
            addr_tgl <= 1'b0;
            wr_tgl   <= 1'b0;
        end else if (state == tap_pkg::TAP_UP_DR) begin
            if (ir == tap_pkg::INS_SAMPLE || ir == tap_pkg::INS_EXTEST)
                bsr_upd <= dr[23:0];
            if (ir == tap_pkg::INS_IFACE)
                if_off <= dr[0];
            if (ir == tap_pkg::INS_REG_RD && if_off) begin
                cur_addr <= dr[6:0];
                addr_tgl <= ~addr_tgl;
            end
            if (ir == tap_pkg::INS_REG_WR && if_off) begin
                wr_addr <= dr[14:tap_pkg::WR_ADDR_LSB];
                wr_data <= dr[7:0];
                wr_tgl  <= ~wr_tgl;
            end
        end
    end

    // read byte taken over when the system side acknowledges
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            rd_tck   <= '0;
            ack_seen <= 1'b0;
        end else begin
            ack_seen <= ack_s;
            if (ack_s != ack_seen)
                rd_tck <= rd_sys;
        end
    end

    // falling edge output keeps a full half period for the next device
    always_ff @(negedge i_tck) begin
        if (!tck_rst_n) begin
            o_tdo    <= 1'b1;
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo_oe <= (state == tap_pkg::TAP_SH_IR) || (state == tap_pkg::TAP_SH_DR);
            if (state == tap_pkg::TAP_SH_IR)
                o_tdo <= ir_sh[0];
            else if (uses_bypass(ir))
                o_tdo <= bypass;
            else
                o_tdo <= dr[0];
        end
    end

    // pad muxing; cell 6 observes only, so pin 3 data stays with the core
    assign drive_test = (ir == tap_pkg::INS_EXTEST) || (ir == tap_pkg::INS_CLAMP);
    generate
        for (k = 0; k < tap_pkg::PIN_N; k++) begin : g_pad
            if (k == tap_pkg::BC4_PIN) begin : g_obs
                assign o_pad_out[k] = i_core_out[k];
            end else begin : g_drv
                assign o_pad_out[k] = drive_test ? bsr_upd[2*k] : i_core_out[k];
            end
            assign o_pad_oe[k] = (ir == tap_pkg::INS_HIGHZ) ? 1'b0 :
                                 drive_test ? bsr_upd[2*k+1] : i_core_oe[k];
        end
    endgenerate

    // system side synchronisers for toggles and interface level
    sync_2ff #(.WIDTH(3)) u_sys_sync (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_en    (i_ce),
        .i_d     ({addr_tgl, wr_tgl, if_off}),
        .o_q     ({addr_s, wr_s, if_off_s})
    );

    // host interface disable level
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n)
            o_host_if_off <= 1'b0;
        else if (i_ce)
            o_host_if_off <= if_off_s;
    end

    // register port; a write wins the address when both arrive together
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_reg_addr  <= '0;
            o_reg_wdata <= '0;
            o_reg_wr    <= 1'b0;
            addr_seen   <= 1'b0;
            wr_seen     <= 1'b0;
            rd_pend     <= 1'b0;
            ack_tgl     <= 1'b0;
            rd_sys      <= '0;
        end else if (i_ce) begin
            wr_seen   <= wr_s;
            o_reg_wr  <= 1'b0;
            if (wr_s != wr_seen) begin
                o_reg_addr  <= wr_addr;
                o_reg_wdata <= wr_data;
                o_reg_wr    <= 1'b1;
            end else if (addr_s != addr_seen) begin
                // read toggle only consumed here, so a colliding read waits a cycle
                addr_seen  <= addr_s;
                o_reg_addr <= cur_addr;
                rd_pend    <= 1'b1;
            end else if (rd_pend) begin
                rd_sys  <= i_reg_rdata;
                ack_tgl <= ~ack_tgl;
                rd_pend <= 1'b0;
            end
        end
    end

    five_tms_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        i_tms [*5] |=> state == tap_pkg::TAP_TLR) else $error("tms high five times missed reset");
    tlr_idcode_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        state == tap_pkg::TAP_TLR |-> ir == tap_pkg::INS_IDCODE) else $error("reset lost idcode");
    tdo_drive_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        o_tdo_oe == (state == tap_pkg::TAP_SH_DR || state == tap_pkg::TAP_SH_IR))
        else $error("tdo enable outside shift");
    tap_step_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        state == tap_pkg::TAP_SEL_DR && !i_tms |=> state == tap_pkg::TAP_CAP_DR)
        else $error("select-dr did not reach capture");
    bypass_path_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        (state == tap_pkg::TAP_SH_DR && ir == tap_pkg::INS_BYPASS) ##1
        (state == tap_pkg::TAP_SH_DR) |-> o_tdo == $past(i_tdi)) else $error("bypass bit wrong");
    id_capture_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        state == tap_pkg::TAP_CAP_DR && ir == tap_pkg::INS_IDCODE |=> dr == id_word && dr[0])
        else $error("idcode capture wrong");
    if_update_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        state == tap_pkg::TAP_UP_DR && ir == tap_pkg::INS_IFACE |=> if_off == $past(dr[0]))
        else $error("interface bit not taken");
    ir_shift_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        state == tap_pkg::TAP_SH_IR ##1 state != tap_pkg::TAP_TLR |-> ir_sh[3] == $past(i_tdi))
        else $error("ir shift lost tdi");
    read_addr_a: assert property (@(posedge i_tck) disable iff (!tck_rst_n)
        state == tap_pkg::TAP_UP_DR && ir == tap_pkg::INS_REG_RD && if_off
        |=> cur_addr == $past(dr[6:0])) else $error("read address not taken");
    write_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_reg_wr && i_ce |=> !o_reg_wr) else $error("write strobe longer than one cycle");
endmodule

// File: jtag_tester.sv
/*
 * Behavioural external scan controller that drives the test port.
 * Assumes the caller invokes its tasks one at a time; the test clock
 * stands still at 0 between frames.
 */
`timescale 1ns/1ps
module jtag_tester (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    int   oe_miss;
    logic q;

    // quiet port: clock low, select high
    initial begin
        o_tck   = 1'b0;
        o_tms   = 1'b1;
        o_tdi   = 1'b1;
        oe_miss = 0;
    end

    // one cycle: inputs move only while the clock is low
    task automatic tick(input logic m, input logic d, input bit sh, output logic t);
        o_tms = m;
        o_tdi = d;
        #32 o_tck = 1'b1;
        t = i_tdo;
        if (sh && i_tdo_oe !== 1'b1) begin
            oe_miss++;
        end
        #32 o_tck = 1'b0;
    endtask

    // idle cycles in run-test/idle, data line keeps changing
    task automatic idle(input int n);
        repeat (n) tick(1'b0, ~o_tdi, 1'b0, q);
    endtask

    task automatic reset5();
        repeat (5) tick(1'b1, ~o_tdi, 1'b0, q);
    endtask

    task automatic to_rti();
        reset5();
        tick(1'b0, ~o_tdi, 1'b0, q);
    endtask

    // full scan from idle back to idle, lsb first
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        dout = '0;
        tick(1'b1, ~o_tdi, 1'b0, q);
        if (ir) begin
            tick(1'b1, ~o_tdi, 1'b0, q);
        end
        tick(1'b0, ~o_tdi, 1'b0, q);
        tick(1'b0, ~o_tdi, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], 1'b1, dout[i]);
        end
        tick(1'b1, ~o_tdi, 1'b0, q);
        tick(1'b0, ~o_tdi, 1'b0, q);
    endtask
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the boundary scan port.
 * Assumes jtag_tester drives the test port and a small register file
 * here answers reads combinationally.
 */
`timescale 1ns/1ps
module tb_top;
    localparam logic [3:0]  VER   = 4'h5;     // arbitrary value
    localparam logic [15:0] PART  = 16'h1234; // arbitrary value
    localparam logic [10:0] MAKER = 11'h155;  // arbitrary value

    logic        i_sys_clk;
    logic        i_rst_n;
    logic        i_ce;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        o_tdo;
    logic        o_tdo_oe;
    logic [2:0]  o_test_pullup_en;
    logic [31:0] i_user_code;
    logic        o_host_if_off;
    logic [6:0]  o_reg_addr;
    logic [7:0]  o_reg_wdata;
    logic        o_reg_wr;
    logic [7:0]  i_reg_rdata;
    logic [11:0] i_core_out;
    logic [11:0] i_core_oe;
    logic [11:0] i_pad_in;
    logic [11:0] o_pad_out;
    logic [11:0] o_pad_oe;
    logic [31:0] q;
    logic [31:0] d;
    logic [23:0] p;
    logic [6:0]  a;
    logic [7:0]  wa;
    logic [7:0]  wd;
    int          n_fail;
    int          total_checks;
    int          n_wr;
    int          w;
    int          seed;
    logic [3:0]  byp_codes [5] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'hb};

    // register file model
    function automatic logic [7:0] rd_exp(input logic [6:0] x);
        return {x, 1'b1} ^ 8'h96;
    endfunction
    assign i_reg_rdata = rd_exp(o_reg_addr);

    // sample capture: pin cells see pads, control cells see core enables
    function automatic logic [23:0] cap_exp();
        logic [23:0] v;
        for (int k = 0; k < 12; k++) begin
            v[2*k]   = i_pad_in[k];
            v[2*k+1] = i_core_oe[k];
        end
        return v;
    endfunction

    // pads from latches {oe,out}; pin 3 data stays with the core
    function automatic logic [23:0] pad_exp(input logic [23:0] l);
        logic [23:0] v;
        for (int k = 0; k < 12; k++) begin
            v[k]    = (k == 3) ? i_core_out[3] : l[2*k];
            v[k+12] = l[2*k+1];
        end
        return v;
    endfunction

    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end

    // write strobe monitor, one cycle pulse is easy to miss by polling
    always @(posedge i_sys_clk) begin
        if (o_reg_wr === 1'b1) begin
            n_wr++;
            wa <= {1'b0, o_reg_addr};
            wd <= o_reg_wdata;
        end
    end

    boundary_scan_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) i_dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_tck(tck),
        .i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
        .o_test_pullup_en(o_test_pullup_en), .i_user_code(i_user_code),
        .o_host_if_off(o_host_if_off), .o_reg_addr(o_reg_addr),
        .o_reg_wdata(o_reg_wdata), .o_reg_wr(o_reg_wr), .i_reg_rdata(i_reg_rdata),
        .i_core_out(i_core_out), .i_core_oe(i_core_oe), .i_pad_in(i_pad_in),
        .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe));

    jtag_tester i_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo),
                        .i_tdo_oe(o_tdo_oe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // every instruction load also checks the captured pattern
    task automatic load_ir(input logic [3:0] c);
        i_host.scan(1'b1, 4, {28'h0, c}, q);
        chk(q, {28'h0, tap_pkg::IR_CAPTURE}, "ir capture");
    endtask

    // hang guard
    initial begin
        #2ms;
        n_fail++;
        end_of_test();
    end

    initial begin
        seed = 32'h1041;
        n_fail = 0;
        total_checks = 0;
        n_wr = 0;
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_user_code = $random(seed);
        i_core_out = 12'($random(seed));
        i_core_oe = 12'($random(seed));
        i_pad_in = 12'($random(seed));
        // tester sets its idle levels at time zero, so start one edge later
        @(negedge i_sys_clk);
        // reset needs edges in both domains, so tck runs meanwhile
        fork
            i_host.reset5();
            repeat (3) @(posedge i_sys_clk);
        join
        @(negedge i_sys_clk) i_rst_n = 1'b1;
        chk(o_tdo_oe, 0, "tdo released");
        chk(o_test_pullup_en, 3'h7, "pull-ups");
        i_host.to_rti();
        i_host.scan(1'b0, 32, $random(seed), q);
        chk(q, {VER, PART, MAKER, 1'b1}, "default id");
        load_ir(tap_pkg::INS_USERCODE);
        i_host.scan(1'b0, 32, $random(seed), q);
        chk(q, i_user_code, "user code");
        chk(o_tdo_oe, 0, "tdo idle");
        // bypass-like codes, unknown ones included
        foreach (byp_codes[i]) begin
            load_ir(byp_codes[i]);
            d = $random(seed);
            i_host.scan(1'b0, 9, d, q);
            chk(q[8:0], {d[7:0], 1'b0}, "bypass");
            if (i == 2) chk(o_pad_oe, 0, "highz pads");
            if (i == 0) chk({o_pad_oe, o_pad_out}, {i_core_oe, i_core_out}, "normal");
        end
        @(negedge i_sys_clk);
        i_pad_in = 12'($random(seed));
        i_core_oe = 12'($random(seed));
        i_core_out = 12'($random(seed));
        p = 24'($random(seed));
        load_ir(tap_pkg::INS_SAMPLE);
        i_host.scan(1'b0, 24, p, q);
        chk(q, cap_exp(), "sample");
        load_ir(tap_pkg::INS_EXTEST);
        chk({o_pad_oe, o_pad_out}, pad_exp(p), "extest pads");
        load_ir(tap_pkg::INS_CLAMP);
        chk({o_pad_oe, o_pad_out}, pad_exp(p), "clamp pads");
        i_host.scan(1'b0, 2, 32'h3, q);
        chk(q[1:0], 2'h2, "clamp bypass");
        chk(i_host.oe_miss, 0, "tdo driven in shift");
        // write refused while host interfaces are on
        w = n_wr;
        load_ir(tap_pkg::INS_REG_WR);
        i_host.scan(1'b0, 15, $random(seed), q);
        i_host.idle(6);
        chk(n_wr - w, 0, "refused write");
        load_ir(tap_pkg::INS_IFACE);
        i_host.scan(1'b0, 1, 32'h1, q);
        i_host.idle(4);
        chk(o_host_if_off, 1, "interfaces off");
        a = 7'($random(seed));
        d = $random(seed);
        load_ir(tap_pkg::INS_REG_WR);
        i_host.scan(1'b0, 15, {17'h0, a, d[7:0]}, q);
        i_host.idle(6);
        chk(n_wr - w, 1, "one write");
        chk({wa, wd}, {1'b0, a, d[7:0]}, "write addr data");
        a = 7'($random(seed));
        load_ir(tap_pkg::INS_REG_RD);
        i_host.scan(1'b0, 8, {25'h0, a}, q);
        i_host.idle(6);
        i_host.scan(1'b0, 8, $random(seed), q);
        chk(q[7:0], rd_exp(a), "register read");
        // abandon a shift midway; five high cycles must reset
        i_host.tick(1'b1, 1'b0, 1'b0, q[0]);
        i_host.tick(1'b0, 1'b0, 1'b0, q[0]);
        i_host.tick(1'b0, 1'b0, 1'b0, q[0]);
        i_host.to_rti();
        chk(o_tdo_oe, 0, "released after reset");
        // tck stands still for a while; state and instruction must hold
        repeat (40) @(negedge i_sys_clk);
        i_host.scan(1'b0, 32, $random(seed), q);
        chk(q, {VER, PART, MAKER, 1'b1}, "id after tms reset");
        end_of_test();
    end
endmodule
